/* File: pkg/aim_pkg.sv */
// shared constants, types and helpers of the analog input range monitor
// assumes a single sys_clk domain; levels arrive as signed millivolts or microamps
`default_nettype none

package aim_pkg;

  // ************************************************************
  // configuration encodings
  // ************************************************************
  typedef enum logic [1:0] {AIM_FMT_BIN16, AIM_FMT_VOLTMETER, AIM_FMT_BIN12} aim_format_e;

  typedef enum logic [2:0] {
    AIM_RNG_BIP10V, AIM_RNG_UNI10V, AIM_RNG_BIP5V, AIM_RNG_UNI5V,
    AIM_RNG_OFS5V, AIM_RNG_BIP20MA, AIM_RNG_UNI20MA, AIM_RNG_OFS20MA
  } aim_range_e;

  localparam int AIM_CHANNELS = 8;
  localparam int AIM_LEVEL_W  = 18;
  localparam int AIM_RANGE_W  = 3;

  typedef logic signed [AIM_LEVEL_W-1:0] aim_level_t;

  // ************************************************************
  // range tables, indexed by aim_range_e, levels in mV or uA
  // ************************************************************
  localparam int AIM_NORM_LO [8] = '{-10000, 0, -5000, 0, 1000, -20000, 0, 4000};
  localparam int AIM_NORM_HI [8] = '{10000, 10000, 5000, 5000, 5000, 20000, 20000, 20000};
  localparam int AIM_OFS16   [8] = '{32768, 0, 32768, 0, 0, 32768, 0, 0};
  localparam int AIM_NUM16   [8] = '{16, 32, 16, 32, 32, 4, 8, 8};
  localparam int AIM_DEN16        = 5;
  localparam int AIM_FLOOR   [8] = '{0, 0, 0, 0, 500, 0, 0, 2080};
  localparam logic [7:0] AIM_HAS_FLOOR  = 8'h90;
  localparam logic [7:0] AIM_LOW_WARN   = 8'hB5;
  localparam logic [7:0] AIM_BIPOLAR    = 8'h25;
  localparam int AIM_OOR_NUM  = 1024;
  localparam int AIM_OOR_DEN  = 1000;

  localparam int AIM_CODE16_MAX = 65535;
  localparam int AIM_CODE12_MAX = 4095;
  localparam int AIM_VM_MIN     = -32768;
  localparam int AIM_VM_MAX     = 32767;

  // ************************************************************
  // register map, word index = byte address / 4
  // ************************************************************
  localparam int AIM_ADR_W    = 8;
  localparam int AIM_WORD_LSB = 2;
  localparam logic [5:0] AIM_REG_CHSTAT  = 6'h08;
  localparam logic [5:0] AIM_REG_MODSTAT = 6'h09;
  localparam logic [5:0] AIM_REG_CONFIG  = 6'h0A;
  localparam logic [5:0] AIM_REG_IRQSTAT = 6'h0B;
  localparam logic [5:0] AIM_REG_IRQMASK = 6'h0C;
  localparam int AIM_CSTAT_OOR_LSB = 8;
  localparam int AIM_MODSTAT_BIT   = 7;
  localparam int AIM_CFG_FMT_LSB   = 24;
  localparam logic [31:0] AIM_CFG_MASK = 32'h03FFFFFF;
  localparam int AIM_EVT_WARN_LSB  = 8;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [AIM_ADR_W-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } aim_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } aim_wb_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    aim_level_t level;
  } aim_sample_s;

  typedef struct packed {
    logic [15:0] code;
    logic        warn;
    logic        oor;
    logic        broken;
  } aim_chan_result_s;

  typedef struct packed {
    logic [7:0][15:0] reading;
    logic [7:0]       warn;
    logic [7:0]       oor;
    logic [7:0]       broken;
    logic             modBit;
    logic [31:0]      cfg;
    logic [15:0]      evt;
    logic [15:0]      mask;
    logic             ack;
    logic [31:0]      rdat;
    logic             irq;
    logic             fault;
  } aim_state_s;

  function automatic int aimClamp(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : aimClamp

  function automatic int aimOorHi(input aim_range_e r);
    return AIM_NORM_HI[r] * AIM_OOR_NUM / AIM_OOR_DEN;
  endfunction : aimOorHi

endpackage : aim_pkg

`default_nettype wire

/* File: core/aim_code_convert.sv */
// per-sample conversion and range check of one channel
// assumes level, range and format are stable in the cycle they are read
`timescale 1ns/1ps
`default_nettype none

module aim_code_convert (
  input  wire aim_pkg::aim_level_t       level,
  input  wire aim_pkg::aim_range_e       range,
  input  wire aim_pkg::aim_format_e      format,
  output var  aim_pkg::aim_chan_result_s result
);
  import aim_pkg::*;

  int lvl;
  int lo;
  int hi;
  int oorHi;
  int scaled;
  logic underOor;

  always_comb begin
    lvl   = int'(level);
    lo    = AIM_NORM_LO[range];
    hi    = AIM_NORM_HI[range];
    oorHi = aimOorHi(range);
    // a cut current loop reads exactly zero
    result.broken = (range == AIM_RNG_OFS20MA) && (lvl == 0);
    if (AIM_HAS_FLOOR[range]) begin
      underOor = lvl < AIM_FLOOR[range];
    end else if (AIM_BIPOLAR[range]) begin
      underOor = lvl < -oorHi;
    end else begin
      underOor = 1'b0;
    end
    result.oor  = (lvl > oorHi) || underOor || result.broken;
    // warning held while out of range
    result.warn = (lvl > hi) || (AIM_LOW_WARN[range] && (lvl < lo)) || result.oor;
    case (format)
      AIM_FMT_VOLTMETER: begin
        scaled = aimClamp(lvl, AIM_VM_MIN, AIM_VM_MAX);
      end
      AIM_FMT_BIN12: begin
        scaled = aimClamp((lvl - lo) * AIM_CODE12_MAX / (hi - lo), 0, AIM_CODE12_MAX);
      end
      default: begin
        scaled = aimClamp(AIM_OFS16[range] + lvl * AIM_NUM16[range] / AIM_DEN16, 0, AIM_CODE16_MAX);
      end
    endcase
    result.code = 16'(scaled);
  end

endmodule : aim_code_convert

`default_nettype wire

/* File: core/aim_range_monitor.sv */
// top of the analog input range monitor: readings, range flags, wishbone slave
// assumes samples come from conversion logic on sys_clk, one channel per pulse
//
// Function
// - ten consecutive read-only input registers
// - registers one to eight hold channels
// - warn above normal band, or below it except in unipolar ranges
// - warning stays set while out of range
// - out of range above 2.4 percent over
// - out of range below floor, offset ranges
// - zero current reading in offset current range means broken wire
// - broken wire drives fault, warn, status
// - status byte msb flags any channel fault
// - module format and per-channel range configured
// - 16-bit format codes per range span
// - 12-bit format clamps to 0..4095
// - voltmeter format signed millivolts or microamps
`timescale 1ns/1ps
`default_nettype none

module aim_range_monitor (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire aim_pkg::aim_wb_req_s  wbReq,
  output var  aim_pkg::aim_wb_rsp_s  wbRsp,
  input  wire aim_pkg::aim_sample_s  sample,
  output var  logic                  irq,
  output var  logic                  faultIndicator
);
  import aim_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic aim_range_e chanRange(input logic [31:0] cfg, input logic [2:0] ch);
    return aim_range_e'(cfg[ch*AIM_RANGE_W +: AIM_RANGE_W]);
  endfunction : chanRange

  function automatic logic [31:0] laneMask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : laneMask

  function automatic logic [31:0] readWord(input aim_state_s s, input logic [5:0] idx);
    logic [31:0] w;
    w = '0;
    if (idx < AIM_REG_CHSTAT) begin
      w[15:0] = s.reading[idx[2:0]];
    end else begin
      case (idx)
        AIM_REG_CHSTAT: begin
          w[7:0] = s.warn;
          w[AIM_CSTAT_OOR_LSB +: 8] = s.oor;
        end
        AIM_REG_MODSTAT: begin
          w[AIM_MODSTAT_BIT] = s.modBit;
        end
        AIM_REG_CONFIG: begin
          w = s.cfg;
        end
        AIM_REG_IRQSTAT: begin
          w[15:0] = s.evt;
        end
        AIM_REG_IRQMASK: begin
          w[15:0] = s.mask;
        end
        default: begin
          w = '0;
        end
      endcase
    end
    return w;
  endfunction : readWord

  // ************************************************************
  // state
  // ************************************************************
  aim_state_s       st_q;
  aim_state_s       st_d;
  aim_chan_result_s res;
  aim_range_e       sampleRange;
  aim_format_e      modFormat;
  logic             reqOn;
  logic [5:0]       idx;
  logic [31:0]      lanes;
  logic [31:0]      merged;
  logic [15:0]      evtClr;

  assign sampleRange = chanRange(st_q.cfg, sample.chan);
  // format code 3 is left undecoded and converts as 16-bit
  assign modFormat   = aim_format_e'(st_q.cfg[AIM_CFG_FMT_LSB +: 2]);

  aim_code_convert u_convert (
    .level  (sample.level),
    .range  (sampleRange),
    .format (modFormat),
    .result (res)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d   = st_q;
    reqOn  = wbReq.cyc && wbReq.stb;
    idx    = wbReq.adr[AIM_ADR_W-1:AIM_WORD_LSB];
    lanes  = laneMask(wbReq.sel);
    merged = '0;
    evtClr = '0;

    // one-wait-state answer, ack dropped the cycle after
    // read data is latched at the take edge; a sample in the wait cycle shows on the next read
    st_d.ack = reqOn && !st_q.ack;
    if (reqOn && !st_q.ack) begin
      st_d.rdat = readWord(st_q, idx);
    end

    // writes land on the edge at which the master sees ack;
    // the ten input registers ignore writes
    if (reqOn && st_q.ack && wbReq.we) begin
      case (idx)
        AIM_REG_CONFIG: begin
          merged   = (st_q.cfg & ~lanes) | (wbReq.dat & lanes);
          st_d.cfg = merged & AIM_CFG_MASK;
        end
        AIM_REG_IRQMASK: begin
          merged    = ({16'h0000, st_q.mask} & ~lanes) | (wbReq.dat & lanes);
          st_d.mask = merged[15:0];
        end
        AIM_REG_IRQSTAT: begin
          evtClr = wbReq.dat[15:0] & lanes[15:0];
        end
        default: begin
          merged = '0;
        end
      endcase
    end
    st_d.evt = st_q.evt & ~evtClr;

    // a new conversion replaces reading and flags; events set after
    // the clear so a same-cycle event survives
    if (sample.valid) begin
      st_d.reading[sample.chan] = res.code;
      st_d.warn[sample.chan]    = res.warn;
      st_d.oor[sample.chan]     = res.oor;
      st_d.broken[sample.chan]  = res.broken;
      if (res.oor && !st_q.oor[sample.chan]) begin
        st_d.evt[sample.chan] = 1'b1;
      end
      if (res.warn && !st_q.warn[sample.chan]) begin
        st_d.evt[AIM_EVT_WARN_LSB + int'(sample.chan)] = 1'b1;
      end
    end

    st_d.modBit = |(st_d.oor | st_d.broken);
    st_d.fault  = |st_d.broken;
    st_d.irq    = |(st_d.evt & st_d.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs, all straight from flip-flops
  // ************************************************************
  assign wbRsp.ack      = st_q.ack;
  assign wbRsp.dat      = st_q.rdat;
  assign irq            = st_q.irq;
  assign faultIndicator = st_q.fault;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (rst);

  a_ack_single_pulse: assert property (
    st_q.ack |=> !st_q.ack
  ) else $error("ack stood longer than one cycle");

  a_ack_after_request: assert property (
    (reqOn && !st_q.ack) |=> st_q.ack
  ) else $error("request not answered in one cycle");

  a_inputs_read_only: assert property (
    (reqOn && st_q.ack && wbReq.we && (idx <= AIM_REG_MODSTAT) && !sample.valid)
      |=> ($stable(st_q.reading) && $stable(st_q.warn) && $stable(st_q.oor))
  ) else $error("write changed an input register");

  a_reading_stored: assert property (
    sample.valid |=> (st_q.reading[$past(sample.chan)] == $past(res.code))
  ) else $error("reading not stored in its channel slot");

  a_warn_band: assert property (
    (sample.valid && (int'(sample.level) > AIM_NORM_HI[sampleRange]))
      |=> st_q.warn[$past(sample.chan)]
  ) else $error("no warning above normal band");

  a_warn_holds_oor: assert property (
    (st_q.oor & ~st_q.warn) == 8'h00
  ) else $error("warning cleared while out of range");

  a_oor_over: assert property (
    (sample.valid && (int'(sample.level) > aimOorHi(sampleRange)))
      |=> st_q.oor[$past(sample.chan)]
  ) else $error("over-range not flagged");

  a_oor_floor: assert property (
    (sample.valid && (sampleRange == AIM_RNG_OFS5V) && (int'(sample.level) < AIM_FLOOR[AIM_RNG_OFS5V]))
      |=> st_q.oor[$past(sample.chan)]
  ) else $error("under-floor not flagged");

  a_broken_wire: assert property (
    (sample.valid && (sampleRange == AIM_RNG_OFS20MA) && (sample.level == '0))
      |=> (faultIndicator && st_q.modBit && st_q.warn[$past(sample.chan)])
  ) else $error("broken wire not reported");

  a_status_msb: assert property (
    (sample.valid && res.oor) |=> st_q.modBit
  ) else $error("status msb missed a fault");

  a_code12_limit: assert property (
    (sample.valid && (modFormat == AIM_FMT_BIN12))
      |=> (st_q.reading[$past(sample.chan)] <= 16'h0FFF)
  ) else $error("12-bit code above limit");

  a_code16_floor: assert property (
    (sample.valid && (modFormat == AIM_FMT_BIN16) && (sampleRange == AIM_RNG_BIP10V)
      && (int'(sample.level) == AIM_NORM_LO[AIM_RNG_BIP10V]))
      |=> (st_q.reading[$past(sample.chan)] == 16'h0300)
  ) else $error("16-bit bipolar floor code wrong");

  a_voltmeter_code: assert property (
    (sample.valid && (modFormat == AIM_FMT_VOLTMETER) && (sampleRange == AIM_RNG_UNI10V)
      && (int'(sample.level) == AIM_NORM_HI[AIM_RNG_UNI10V]))
      |=> (st_q.reading[$past(sample.chan)] == 16'h2710)
  ) else $error("voltmeter code wrong");

  a_irq_follows: assert property (
    $rose(|(st_q.evt & st_q.mask)) |-> irq
  ) else $error("irq not raised with status");

  // ************************************************************
  // read answers and register writes
  // ************************************************************
  a_channel_read: assert property (
    (reqOn && !st_q.ack && !wbReq.we && (idx < AIM_REG_CHSTAT))
      |=> (wbRsp.dat == {16'h0000, $past(st_q.reading[idx[2:0]])})
  ) else $error("channel reading answered wrong");

  a_chstat_read: assert property (
    (reqOn && !st_q.ack && !wbReq.we && (idx == AIM_REG_CHSTAT))
      |=> (wbRsp.dat == {16'h0000, $past(st_q.oor), $past(st_q.warn)})
  ) else $error("channel status word wrong");

  a_modstat_read: assert property (
    (reqOn && !st_q.ack && !wbReq.we && (idx == AIM_REG_MODSTAT))
      |=> (wbRsp.dat == {24'h000000, $past(|(st_q.oor | st_q.broken)), 7'h00})
  ) else $error("status byte msb wrong");

  a_unmapped_zero: assert property (
    (reqOn && !st_q.ack && !wbReq.we && (idx > AIM_REG_IRQMASK))
      |=> (wbRsp.dat == 32'h00000000)
  ) else $error("unmapped word read nonzero");

  a_config_write: assert property (
    (reqOn && st_q.ack && wbReq.we && (idx == AIM_REG_CONFIG) && (wbReq.sel == 4'hF))
      |=> (st_q.cfg == ($past(wbReq.dat) & AIM_CFG_MASK))
  ) else $error("config write lost");

  a_mask_write: assert property (
    (reqOn && st_q.ack && wbReq.we && (idx == AIM_REG_IRQMASK) && (wbReq.sel == 4'hF))
      |=> (st_q.mask == $past(wbReq.dat[15:0]))
  ) else $error("mask write lost");

  a_evt_clear: assert property (
    (reqOn && st_q.ack && wbReq.we && (idx == AIM_REG_IRQSTAT) && (wbReq.sel == 4'hF) && !sample.valid)
      |=> (st_q.evt == ($past(st_q.evt) & ~$past(wbReq.dat[15:0])))
  ) else $error("status clear wrong");

  a_ack_idle: assert property (
    !reqOn |=> !st_q.ack
  ) else $error("ack without request");

  // ************************************************************
  // flags and codes per sample
  // ************************************************************
  a_warn_low_band: assert property (
    (sample.valid && AIM_LOW_WARN[sampleRange] && (int'(sample.level) < AIM_NORM_LO[sampleRange]))
      |=> st_q.warn[$past(sample.chan)]
  ) else $error("no warning below normal band");

  a_in_band_clear: assert property (
    (sample.valid && (int'(sample.level) >= AIM_NORM_LO[sampleRange])
      && (int'(sample.level) <= AIM_NORM_HI[sampleRange]))
      |=> (!st_q.warn[$past(sample.chan)] && !st_q.oor[$past(sample.chan)])
  ) else $error("flag set inside normal band");

  a_oor_negative: assert property (
    (sample.valid && AIM_BIPOLAR[sampleRange] && (int'(sample.level) < -aimOorHi(sampleRange)))
      |=> st_q.oor[$past(sample.chan)]
  ) else $error("negative over-range not flagged");

  a_oor_floor_current: assert property (
    (sample.valid && (sampleRange == AIM_RNG_OFS20MA) && (int'(sample.level) < AIM_FLOOR[AIM_RNG_OFS20MA]))
      |=> st_q.oor[$past(sample.chan)]
  ) else $error("under-floor current not flagged");

  a_broken_current_only: assert property (
    (sample.valid && ((sampleRange != AIM_RNG_OFS20MA) || (sample.level != '0)))
      |=> !st_q.broken[$past(sample.chan)]
  ) else $error("broken wire flagged without zero current");

  a_code12_floor: assert property (
    (sample.valid && (modFormat == AIM_FMT_BIN12) && (int'(sample.level) <= AIM_NORM_LO[sampleRange]))
      |=> (st_q.reading[$past(sample.chan)] == 16'h0000)
  ) else $error("12-bit code below band not zero");

  a_event_set_wins: assert property (
    (sample.valid && res.oor && !st_q.oor[sample.chan])
      |=> st_q.evt[$past(sample.chan)]
  ) else $error("out-of-range event lost");

  c_read_channel: cover property (reqOn && !wbReq.we && (idx < AIM_REG_CHSTAT) ##1 st_q.ack);
  c_oor_event:    cover property (sample.valid && res.oor ##1 irq);
  c_broken:       cover property (sample.valid && res.broken ##1 faultIndicator);
  c_status_clear: cover property (reqOn && wbReq.we && (idx == AIM_REG_IRQSTAT) ##2 !irq);
  c_voltmeter:    cover property (sample.valid && (modFormat == AIM_FMT_VOLTMETER));

endmodule : aim_range_monitor

`default_nettype wire

/* File: verification/aim_ctrl_model.sv */
// controller model: classic wishbone master that configures and reads the monitor
// assumes one sys_clk; the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none

module aim_ctrl_model (
  input  wire logic                 sys_clk,
  output var  aim_pkg::aim_wb_req_s wbReq,
  input  wire aim_pkg::aim_wb_rsp_s wbRsp
);
  import aim_pkg::*;

  initial wbReq = '0;

  // ****************
  // bus cycle
  // ****************
  // no fixed latency is assumed: the request stands until ack is seen
  task automatic access(input logic we, input logic [5:0] idx, input logic [31:0] wdat,
                        output logic [31:0] rdat);
    @(posedge sys_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0}, sel: 4'hF, dat: wdat};
    do @(posedge sys_clk); while (wbRsp.ack !== 1'b1);
    rdat = wbRsp.dat;
    wbReq <= '0;
  endtask : access

  // one format for the module, one range per channel, in a single write
  task automatic setup(input logic [1:0] fmt, input logic [23:0] ranges);
    logic [31:0] unused;
    access(1'b1, AIM_REG_CONFIG, {6'h0, fmt, ranges}, unused);
  endtask : setup
endmodule : aim_ctrl_model

`default_nettype wire

/* File: verification/aim_range_monitor_test.sv */
// self-checking bench of the range monitor against a behavioural model
// assumes aim_ctrl_model as bus master; samples are driven from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end

module aim_range_monitor_test;
  import aim_pkg::*;
  localparam int LEVELS [20] = '{0, 499, 500, 999, 1000, 2079, 2080, 3999, 4000, 5001, 5121,
                                 10001, 10240, 10241, 20001, 20481, -1, -5121, -10241, -20481};
  logic        sys_clk;
  logic        rst;
  aim_wb_req_s wbReq;
  aim_wb_rsp_s wbRsp;
  aim_sample_s sample;
  logic        irq;
  logic        faultIndicator;
  int          err_total;
  int          n_checks;
  int          cycleCount = 0;
  int          fmt;
  int          rng [8];
  logic [15:0] expRd [8];
  logic [7:0]  expWarn;
  logic [7:0]  expOor;
  logic [7:0]  expBroken;
  logic [15:0] expEvt;
  logic [15:0] mask;
  logic [31:0] rd;
  logic [31:0] cfg;

  aim_range_monitor uut (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
                         .sample(sample), .irq(irq), .faultIndicator(faultIndicator));
  aim_ctrl_model ctrl (.sys_clk(sys_clk), .wbReq(wbReq), .wbRsp(wbRsp));

  // ****************
  // reference model
  // ****************
  function automatic logic [15:0] expCode(input int r, input int v);
    int c;
    if (fmt == 1) c = (v < -32768) ? -32768 : ((v > 32767) ? 32767 : v);
    else if (fmt == 2) c = (v - AIM_NORM_LO[r]) * 4095 / (AIM_NORM_HI[r] - AIM_NORM_LO[r]);
    else c = AIM_OFS16[r] + v * AIM_NUM16[r] / 5;
    if (fmt != 1) c = (c < 0) ? 0 : ((c > ((fmt == 2) ? 4095 : 65535)) ? ((fmt == 2) ? 4095 : 65535) : c);
    return c[15:0];
  endfunction : expCode

  task automatic applySample(input int ch, input int v);
    int   r;
    int   oorHi;
    logic o;
    logic w;
    r = rng[ch];
    oorHi = AIM_NORM_HI[r] * 1024 / 1000;
    o = v > oorHi || (AIM_BIPOLAR[r] && v < -oorHi) || (AIM_HAS_FLOOR[r] && v < AIM_FLOOR[r]);
    w = o || v > AIM_NORM_HI[r] || (AIM_LOW_WARN[r] && v < AIM_NORM_LO[r]);
    expEvt[ch] |= o & ~expOor[ch];
    expEvt[8 + ch] |= w & ~expWarn[ch];
    expOor[ch] = o;
    expWarn[ch] = w;
    expBroken[ch] = (r == 7) && (v == 0);
    expRd[ch] = expCode(r, v);
    @(posedge sys_clk);
    sample <= '{valid: 1'b1, chan: ch[2:0], level: v[AIM_LEVEL_W-1:0]};
    @(posedge sys_clk);
    sample.valid <= 1'b0;
  endtask : applySample

  // every channel is read back so a write to the wrong register shows up
  task automatic checkAll();
    for (int c = 0; c < 8; c++) begin
      ctrl.access(1'b0, c[5:0], 32'h0, rd);
      if (fmt == 2) `CHK(rd, {16'h0, expRd[c]})
      else if (fmt == 1) `CHK(rd, {16'h0, expRd[c]})
      else `CHK(rd, {16'h0, expRd[c]})
    end
    ctrl.access(1'b0, AIM_REG_CHSTAT, 32'h0, rd);
    `CHK(rd[7:0], expWarn)
    `CHK(rd[15:8], expOor)
    `CHK(rd[31:16], 16'h0)
    ctrl.access(1'b0, AIM_REG_MODSTAT, 32'h0, rd);
    `CHK(rd, {24'h0, |(expOor | expBroken), 7'h0})
    ctrl.access(1'b0, AIM_REG_IRQSTAT, 32'h0, rd);
    `CHK(rd, {16'h0, expEvt})
    `CHK(irq, |(expEvt & mask))
    `CHK(faultIndicator, |expBroken)
  endtask : checkAll

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // ****************
  // clock, timeout, sequence
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // the full run needs about 6000 cycles
  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    int ch;
    int v;
    rst = 1'b1;
    sample = '0;
    err_total = 0;
    n_checks = 0;
    fmt = 0;
    rng = '{default: 0};
    expRd = '{default: 16'h0};
    {expWarn, expOor, expBroken, expEvt, mask} = '0;
    void'($urandom(93915));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    checkAll();
    ctrl.access(1'b0, AIM_REG_CONFIG, 32'h0, rd);
    `CHK(rd, 32'h0)
    // format code 3 is not decoded and must behave as 16-bit
    for (fmt = 0; fmt < 4; fmt++) begin
      cfg = {6'h0, fmt[1:0], 24'($urandom)};
      if (fmt == 0) cfg[23:21] = 3'h7;
      // channel 0 gets a fixed range for the directed end-point sample
      cfg[2:0] = (fmt == 1) ? 3'h1 : 3'h0;
      mask = 16'($urandom);
      ctrl.setup(fmt[1:0], cfg[23:0]);
      ctrl.access(1'b1, AIM_REG_IRQMASK, {16'h0, mask}, rd);
      ctrl.access(1'b0, AIM_REG_CONFIG, 32'h0, rd);
      `CHK(rd, cfg)
      for (int c = 0; c < 8; c++) rng[c] = cfg[3*c +: 3];
      for (int k = 0; k < 40; k++) begin
        ch = (k == 0) ? 7 : ((k == 1) ? 0 : $urandom_range(7, 0));
        if (k < 2) v = (k == 0) ? 0 : ((fmt == 1) ? 10000 : -10000);
        else v = k[0] ? LEVELS[$urandom_range(19, 0)] : $urandom_range(44000, 0) - 22000;
        applySample(ch, v);
        checkAll();
      end
      ctrl.access(1'b1, AIM_REG_IRQSTAT, 32'h0000FFFF, rd);
      expEvt = '0;
      checkAll();
    end
    // read-only input words ignore writes; unmapped words read zero
    ctrl.access(1'b1, 6'h00, 32'hFFFFFFFF, rd);
    ctrl.access(1'b0, 6'h00, 32'h0, rd);
    `CHK(rd, {16'h0, expRd[0]})
    ctrl.access(1'b0, 6'h0D, 32'h0, rd);
    `CHK(rd, 32'h0)
    give_verdict();
  end
endmodule : aim_range_monitor_test

`default_nettype wire
